// ===== rtl/soamon_top.sv
`timescale 1ns/100ps
// Function
// - Disabled types cause no reaction, except that max_power_cap_out is derated even with temperature disabled
// - Single enable query answers channel, type, flag
// - Type codes zero to nine fixed
// - Internal watchdog always enabled, input ignored
// - Types three five six never act
// - Short enable query returns eight flags
// - Software watchdog flag always reads zero
// - Defaults: temperature, reflection, current enabled
// - High reflection flags and throttles
// - Shutdown reflection errors and disables RF
// - Gain loop tracks forward power setpoint
// - High reflection: regulate reflection to limit
// - Reflection threshold query, default 47.25 dBm
// - High temperature raises warning flag
// - Shutdown temperature errors and disables RF
// - Clamp forward power above derated cap
// - Below high threshold cap is unmodified
// - Linear cap derating between thresholds
// - Temperature threshold query, defaults 55/65 C
// - Status bits held until clear command
// - RF enable refused until error cleared
module soamon_top
  import soamon_pkg::*;
(
  input  wire logic                            mclk_in,
  input  wire logic                            reset_n_in,
  // Configuration
  input  wire logic                            cfg_we_in,
  input  wire logic [3:0]                      cfg_type_in,
  input  wire logic                            cfg_enable_in,
  input  wire logic                            thr_we_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   refl_high_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   refl_shdn_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   temp_high_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   temp_shdn_in,
  input  wire logic [soamon_pkg::CAP_W-1:0]    max_power_cap_in,
  input  wire logic                            autogain_in,
  // Measurements
  input  wire logic                            sample_valid_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   fwd_meas_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   refl_meas_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   temp_meas_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]   fwd_setpoint_in,
  input  wire logic [soamon_pkg::CAP_W-1:0]    fwd_watts_in,
  // RF control
  input  wire logic                            rf_on_req_in,
  input  wire logic                            rf_off_req_in,
  input  wire logic                            clear_errors_command_in,
  output logic                                 rf_enable_out,
  output logic                                 rf_on_refused_out,
  output logic      [soamon_pkg::STATUS_W-1:0] status_out,
  output logic                                 drive_up_out,
  output logic                                 drive_down_out,
  output logic      [soamon_pkg::CAP_W-1:0]    max_power_cap_out,
  // Queries
  input  wire logic                            query_valid_in,
  input  wire soamon_pkg::soamon_query_t       query_kind_in,
  input  wire logic [soamon_pkg::CHAN_W-1:0]   query_chan_in,
  input  wire logic [3:0]                      query_type_in,
  output logic                                 reply_valid_out,
  output soamon_pkg::soamon_query_t            reply_kind_out,
  output logic      [soamon_pkg::CHAN_W-1:0]   reply_chan_out,
  output logic      [3:0]                      reply_type_out,
  output logic      [7:0]                      reply_flags_out,
  output logic      [soamon_pkg::MEAS_W-1:0]   reply_thr_a_out,
  output logic      [soamon_pkg::MEAS_W-1:0]   reply_thr_b_out
);
  import soamon_pkg::*;

  // ==========================================================================
  // Reset release
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic       rst_n;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // Only the second flop feeds the rest of the block
  assign rst_n = rst_s2_r;

  // ==========================================================================
  // Enables and thresholds
  logic [SOA_TYPES-1:0] enable_r;
  logic [MEAS_W-1:0]    refl_high_r;
  logic [MEAS_W-1:0]    refl_shdn_r;
  logic [MEAS_W-1:0]    temp_high_r;
  logic [MEAS_W-1:0]    temp_shdn_r;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable_r <= ENABLE_RESET;
    end else if (cfg_we_in && cfg_type_in < 4'(SOA_TYPES)
                 && cfg_type_in != SOA_TYPE_INT_WDG) begin
      enable_r[cfg_type_in] <= cfg_enable_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      refl_high_r <= REFL_HIGH_RESET;
      refl_shdn_r <= REFL_SHDN_RESET;
      temp_high_r <= TEMP_HIGH_RESET;
      temp_shdn_r <= TEMP_SHDN_RESET;
    end else if (thr_we_in) begin
      refl_high_r <= refl_high_in;
      refl_shdn_r <= refl_shdn_in;
      temp_high_r <= temp_high_in;
      temp_shdn_r <= temp_shdn_in;
    end
  end

  // Internal watchdog reads enabled whatever was stored
  function automatic logic type_enabled(input logic [SOA_TYPES-1:0] en,
                                        input logic [3:0] t);
    if (t == SOA_TYPE_INT_WDG) begin
      type_enabled = 1'b1;
    end else if (t < 4'(SOA_TYPES)) begin
      type_enabled = en[t];
    end else begin
      type_enabled = 1'b0;
    end
  endfunction

  // Unused types are masked so they can never act
  logic [SOA_TYPES-1:0] act_en;
  assign act_en = enable_r & ~UNUSED_MASK;

  // ==========================================================================
  // Comparisons, taken only on a new sample
  logic temp_high_hit;
  logic temp_shdn_hit;
  logic refl_high_hit;
  logic refl_shdn_hit;

  assign temp_shdn_hit = act_en[SOA_TYPE_TEMP] && temp_meas_in > temp_shdn_r;
  assign temp_high_hit = act_en[SOA_TYPE_TEMP] && temp_meas_in > temp_high_r
                         && !temp_shdn_hit;
  assign refl_shdn_hit = act_en[SOA_TYPE_REFL] && refl_meas_in > refl_shdn_r;
  assign refl_high_hit = act_en[SOA_TYPE_REFL] && refl_meas_in > refl_high_r
                         && !refl_shdn_hit;

  logic [STATUS_W-1:0] event_bits;
  always_comb begin
    event_bits = '0;
    if (sample_valid_in) begin
      event_bits[ST_TEMP_HIGH] = temp_high_hit;
      event_bits[ST_TEMP_SHDN] = temp_shdn_hit;
      event_bits[ST_REFL_HIGH] = refl_high_hit;
      event_bits[ST_REFL_SHDN] = refl_shdn_hit;
    end
  end

  // ==========================================================================
  // Sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_out <= '0;
    end else if (clear_errors_command_in) begin
      status_out <= event_bits;
    end else begin
      status_out <= status_out | event_bits;
    end
  end

  logic shdn_err;
  assign shdn_err = status_out[ST_TEMP_SHDN] | status_out[ST_REFL_SHDN];

  // ==========================================================================
  // RF enable
  logic shdn_now;
  assign shdn_now = event_bits[ST_TEMP_SHDN] | event_bits[ST_REFL_SHDN];

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rf_enable_out     <= 1'b0;
      rf_on_refused_out <= 1'b0;
    end else begin
      // A refused attempt is reported even when an off request wins the cycle
      rf_on_refused_out <= rf_on_req_in && shdn_err && !clear_errors_command_in;
      if (shdn_now || rf_off_req_in) begin
        rf_enable_out <= 1'b0;
      end else if (rf_on_req_in) begin
        if (!shdn_err || clear_errors_command_in) begin
          rf_enable_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Power cap derating
  logic derate_done;

  soamon_derate u_derate (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n),
    .start_in     (sample_valid_in),
    .temp_in      (temp_meas_in),
    .temp_high_in (temp_high_r),
    .temp_shdn_in (temp_shdn_r),
    .cap_in       (max_power_cap_in),
    .done_out     (derate_done),
    .cap_out      (max_power_cap_out)
  );

  logic cap_ready_r;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_ready_r <= 1'b0;
    end else if (derate_done) begin
      cap_ready_r <= 1'b1;
    end
  end

  // ==========================================================================
  // Gain loop steering, one step per sample
  logic temp_throttle;
  assign temp_throttle = act_en[SOA_TYPE_TEMP] && temp_meas_in > temp_high_r
                         && cap_ready_r && fwd_watts_in > max_power_cap_out;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      drive_up_out   <= 1'b0;
      drive_down_out <= 1'b0;
    end else begin
      drive_up_out   <= 1'b0;
      drive_down_out <= 1'b0;
      if (sample_valid_in && rf_enable_out && autogain_in) begin
        if (refl_high_hit) begin
          drive_down_out <= refl_meas_in > refl_high_r;
        end else if (temp_throttle) begin
          drive_down_out <= 1'b1;
        end else if (fwd_meas_in < fwd_setpoint_in) begin
          drive_up_out <= 1'b1;
        end else if (fwd_meas_in > fwd_setpoint_in) begin
          drive_down_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Query replies, one cycle after the request
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      reply_valid_out <= 1'b0;
      reply_kind_out  <= SOAMON_Q_NONE;
      reply_chan_out  <= '0;
      reply_type_out  <= '0;
      reply_flags_out <= 8'h00;
      reply_thr_a_out <= '0;
      reply_thr_b_out <= '0;
    end else begin
      reply_valid_out <= query_valid_in;
      if (query_valid_in) begin
        reply_kind_out  <= query_kind_in;
        reply_chan_out  <= query_chan_in;
        reply_type_out  <= 4'h0;
        reply_flags_out <= 8'h00;
        reply_thr_a_out <= '0;
        reply_thr_b_out <= '0;
        unique case (query_kind_in)
          SOAMON_Q_ENABLE_ONE: begin
            reply_type_out  <= query_type_in;
            reply_flags_out <= {7'h00, type_enabled(enable_r, query_type_in)};
          end
          SOAMON_Q_ENABLE_ALL: begin
            reply_flags_out <= enable_r[SHORT_FLAGS-1:0] & 8'hfd;
          end
          SOAMON_Q_REFL_THR: begin
            reply_thr_a_out <= refl_high_r;
            reply_thr_b_out <= refl_shdn_r;
          end
          SOAMON_Q_TEMP_THR: begin
            reply_thr_a_out <= temp_high_r;
            reply_thr_b_out <= temp_shdn_r;
          end
          default: begin
            reply_kind_out <= SOAMON_Q_NONE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence s_shdn_event;
    sample_valid_in && (temp_shdn_hit || refl_shdn_hit);
  endsequence

  chk_shdn_kills_rf: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_shdn_event |=> !rf_enable_out) else $error("RF stayed on after shutdown");
  chk_shdn_sticky: assert property (@(posedge mclk_in) disable iff (!rst_n)
    s_shdn_event ##1 !clear_errors_command_in |=> shdn_err) else $error("status lost");
  chk_refuse_on: assert property (@(posedge mclk_in) disable iff (!rst_n)
    shdn_err && rf_on_req_in && !clear_errors_command_in && !shdn_now
    |=> !rf_enable_out && rf_on_refused_out) else $error("RF on not refused");
  chk_disabled_quiet: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !enable_r[SOA_TYPE_TEMP] && !enable_r[SOA_TYPE_REFL] |-> event_bits == '0)
    else $error("disabled type reacted");
  chk_wdg_flag_zero: assert property (@(posedge mclk_in) disable iff (!rst_n)
    reply_valid_out && reply_kind_out == SOAMON_Q_ENABLE_ALL |-> !reply_flags_out[1])
    else $error("watchdog flag nonzero");
  chk_wdg_always_on: assert property (@(posedge mclk_in) disable iff (!rst_n)
    query_valid_in && query_kind_in == SOAMON_Q_ENABLE_ONE && query_type_in == SOA_TYPE_INT_WDG
    |=> reply_flags_out[0]) else $error("watchdog reported off");
  chk_refl_throttle: assert property (@(posedge mclk_in) disable iff (!rst_n)
    sample_valid_in && rf_enable_out && autogain_in && refl_high_hit
    |=> drive_down_out && !drive_up_out) else $error("no reflection throttle");
  chk_unused_silent: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (act_en & UNUSED_MASK) == '0) else $error("unused type active");
  chk_thr_reply: assert property (@(posedge mclk_in) disable iff (!rst_n)
    query_valid_in && query_kind_in == SOAMON_Q_REFL_THR
    |=> reply_thr_a_out == $past(refl_high_r) && reply_valid_out) else $error("bad thr reply");
  chk_temp_warn_flag: assert property (@(posedge mclk_in) disable iff (!rst_n)
    sample_valid_in && temp_high_hit |=> status_out[ST_TEMP_HIGH])
    else $error("temperature warning missing");
  chk_temp_shdn_off: assert property (@(posedge mclk_in) disable iff (!rst_n)
    sample_valid_in && temp_shdn_hit |=> !rf_enable_out && status_out[ST_TEMP_SHDN])
    else $error("temperature shutdown missed");
  chk_short_flags: assert property (@(posedge mclk_in) disable iff (!rst_n)
    query_valid_in && query_kind_in == SOAMON_Q_ENABLE_ALL
    |=> reply_flags_out[0] == $past(enable_r[0]) && reply_flags_out[7:2] == $past(enable_r[7:2]))
    else $error("short enable reply wrong");
  chk_gain_track: assert property (@(posedge mclk_in) disable iff (!rst_n)
    sample_valid_in && rf_enable_out && autogain_in && !refl_high_hit && !temp_throttle
    && fwd_meas_in < fwd_setpoint_in |=> drive_up_out && !drive_down_out)
    else $error("gain loop did not raise drive");
  chk_clear_drops: assert property (@(posedge mclk_in) disable iff (!rst_n)
    clear_errors_command_in && !sample_valid_in |=> status_out == '0)
    else $error("status not cleared");
endmodule // soamon_top

// ===== rtl/soamon_pkg.sv
package soamon_pkg;
  // ==========================================================================
  // Protection type codes
  localparam logic [3:0] SOA_TYPE_TEMP     = 4'h0;
  localparam logic [3:0] SOA_TYPE_INT_WDG  = 4'h1;
  localparam logic [3:0] SOA_TYPE_REFL     = 4'h2;
  localparam logic [3:0] SOA_TYPE_EXT_WDG  = 4'h3;
  localparam logic [3:0] SOA_TYPE_DISS     = 4'h4;
  localparam logic [3:0] SOA_TYPE_PA_STAT  = 4'h5;
  localparam logic [3:0] SOA_TYPE_IQ_LOCK  = 4'h6;
  localparam logic [3:0] SOA_TYPE_CURRENT  = 4'h7;
  localparam logic [3:0] SOA_TYPE_VOLTAGE  = 4'h8;
  localparam logic [3:0] SOA_TYPE_FWD_PWR  = 4'h9;
  localparam int         SOA_TYPES         = 10;
  localparam int         SHORT_FLAGS       = 8;

  // ==========================================================================
  // Default enables, bit n is type n
  localparam logic [9:0] ENABLE_RESET      = 10'h085;
  // Types with no protective action on this variant
  localparam logic [9:0] UNUSED_MASK       = 10'h068;

  // ==========================================================================
  // Measurement formats
  // Power in 0.01 dBm units, temperature in 0.1 C units, power cap in 0.1 W
  localparam int         MEAS_W            = 16;
  localparam int         CAP_W             = 16;
  localparam int         CHAN_W            = 4;
  localparam logic [15:0] REFL_HIGH_RESET  = 16'h1275;  // 47.25 dBm
  localparam logic [15:0] REFL_SHDN_RESET  = 16'h1284;  // 47.40 dBm
  localparam logic [15:0] TEMP_HIGH_RESET  = 16'h0226;  // 55.0 C
  localparam logic [15:0] TEMP_SHDN_RESET  = 16'h028a;  // 65.0 C

  // ==========================================================================
  // Status bit positions
  localparam int         ST_TEMP_HIGH      = 1;
  localparam int         ST_TEMP_SHDN      = 2;
  localparam int         ST_REFL_HIGH      = 3;
  localparam int         ST_REFL_SHDN      = 4;
  localparam int         STATUS_W          = 5;

  // ==========================================================================
  // Query kinds
  typedef enum logic [2:0] {
    SOAMON_Q_ENABLE_ONE,
    SOAMON_Q_ENABLE_ALL,
    SOAMON_Q_REFL_THR,
    SOAMON_Q_TEMP_THR,
    SOAMON_Q_NONE
  } soamon_query_t;
endpackage

// ===== rtl/soamon_derate.sv
`timescale 1ns/100ps
// ============================================================================
// Linear derating of the power cap between the high and shutdown temperatures
module soamon_derate
  import soamon_pkg::*;
(
  input  wire logic                           mclk_in,
  input  wire logic                           rst_n_in,
  input  wire logic                           start_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]  temp_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]  temp_high_in,
  input  wire logic [soamon_pkg::MEAS_W-1:0]  temp_shdn_in,
  input  wire logic [soamon_pkg::CAP_W-1:0]   cap_in,
  output logic                                done_out,
  output logic      [soamon_pkg::CAP_W-1:0]   cap_out
);
  // Sequential divider: one quotient bit per cycle keeps the area small
  logic [31:0] num_r;
  logic [16:0] den_r;
  logic [31:0] quo_r;
  logic [32:0] rem_r;
  logic [5:0]  cnt_r;
  logic        busy_r;
  logic [32:0] trial;

  always_comb begin
    trial = {rem_r[31:0], num_r[31]} - {16'h0000, den_r};
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      num_r    <= 32'h0;
      den_r    <= 17'h0;
      quo_r    <= 32'h0;
      rem_r    <= 33'h0;
      cnt_r    <= 6'h0;
      busy_r   <= 1'b0;
      done_out <= 1'b0;
      cap_out  <= 16'h0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !busy_r) begin
        if (temp_in <= temp_high_in || temp_shdn_in <= temp_high_in) begin
          cap_out  <= cap_in;
          done_out <= 1'b1;
        end else if (temp_in >= temp_shdn_in) begin
          cap_out  <= 16'h0;
          done_out <= 1'b1;
        end else begin
          num_r  <= {16'h0000, cap_in} * {16'h0000, temp_shdn_in - temp_in};
          den_r  <= {1'b0, temp_shdn_in - temp_high_in};
          rem_r  <= 33'h0;
          quo_r  <= 32'h0;
          cnt_r  <= 6'd32;
          busy_r <= 1'b1;
        end
      end else if (busy_r) begin
        num_r <= {num_r[30:0], 1'b0};
        if (!trial[32]) begin
          rem_r <= trial;
          quo_r <= {quo_r[30:0], 1'b1};
        end else begin
          rem_r <= {rem_r[31:0], num_r[31]};
          quo_r <= {quo_r[30:0], 1'b0};
        end
        cnt_r <= cnt_r - 6'd1;
        if (cnt_r == 6'd1) begin
          busy_r   <= 1'b0;
          done_out <= 1'b1;
          cap_out  <= trial[32] ? {quo_r[14:0], 1'b0} : {quo_r[14:0], 1'b1};
        end
      end
    end
  end
endmodule // soamon_derate

// ===== sim/soamon_host_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Host side: turns a bench request into a one-cycle query strobe
module soamon_host_model
  import soamon_pkg::*;
(
  input  wire logic                   mclk_in,
  input  wire logic                   req_in,
  input  wire soamon_pkg::soamon_query_t kind_in,
  input  wire logic [3:0]             chan_in,
  input  wire logic [3:0]             type_in,
  output logic                        query_valid_out,
  output soamon_pkg::soamon_query_t   query_kind_out,
  output logic      [3:0]             query_chan_out,
  output logic      [3:0]             query_type_out
);
  import soamon_pkg::*;
  initial begin
    query_valid_out = 1'b0;
    query_kind_out  = SOAMON_Q_NONE;
    query_chan_out  = 4'h0;
    query_type_out  = 4'h0;
  end
  always @(posedge mclk_in) begin
    query_valid_out <= req_in;
    if (req_in) begin
      query_kind_out <= kind_in;
      query_chan_out <= chan_in;
      query_type_out <= type_in;
    end else begin
      // Released channel and type fields flip so a stale value is never mistaken for data
      query_chan_out <= ~query_chan_out;
      query_type_out <= ~query_type_out;
    end
  end
endmodule // soamon_host_model

// ===== sim/soamon_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm,ex,gt) begin tests_run++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module soamon_tb_top;
  import soamon_pkg::*;
  logic mclk_in = 0, reset_n_in = 0, cfg_we_in = 0, cfg_enable_in = 0, thr_we_in = 0;
  logic autogain_in = 0, sample_valid_in = 0, rf_on_req_in = 0, rf_off_req_in = 0;
  logic clear_errors_command_in = 0, query_valid_in, h_req = 0;
  logic [3:0] cfg_type_in = 0, query_chan_in, query_type_in, h_chan = 0, h_type = 0;
  logic [MEAS_W-1:0] refl_high_in = 0, refl_shdn_in = 0, temp_high_in = 0, temp_shdn_in = 0;
  logic [MEAS_W-1:0] max_power_cap_in = 0, fwd_meas_in = 0, refl_meas_in = 0;
  logic [MEAS_W-1:0] temp_meas_in = 0, fwd_setpoint_in = 0, fwd_watts_in = 0;
  soamon_query_t query_kind_in, reply_kind_out, h_kind = SOAMON_Q_NONE;
  logic rf_enable_out, rf_on_refused_out, drive_up_out, drive_down_out, reply_valid_out;
  logic [4:0] status_out;
  logic [3:0] reply_chan_out, reply_type_out;
  logic [7:0] reply_flags_out;
  logic [15:0] max_power_cap_out, reply_thr_a_out, reply_thr_b_out;
  int n_errors = 0, tests_run = 0, cyc = 0;

  soamon_top uut (.mclk_in, .reset_n_in, .cfg_we_in, .cfg_type_in, .cfg_enable_in,
    .thr_we_in, .refl_high_in, .refl_shdn_in, .temp_high_in, .temp_shdn_in,
    .max_power_cap_in, .autogain_in, .sample_valid_in, .fwd_meas_in, .refl_meas_in,
    .temp_meas_in, .fwd_setpoint_in, .fwd_watts_in, .rf_on_req_in, .rf_off_req_in,
    .clear_errors_command_in, .rf_enable_out, .rf_on_refused_out, .status_out,
    .drive_up_out, .drive_down_out, .max_power_cap_out, .query_valid_in, .query_kind_in,
    .query_chan_in, .query_type_in, .reply_valid_out, .reply_kind_out, .reply_chan_out,
    .reply_type_out, .reply_flags_out, .reply_thr_a_out, .reply_thr_b_out);
  soamon_host_model host (.mclk_in, .req_in(h_req), .kind_in(h_kind), .chan_in(h_chan),
    .type_in(h_type), .query_valid_out(query_valid_in), .query_kind_out(query_kind_in),
    .query_chan_out(query_chan_in), .query_type_out(query_type_in));

  always #10 mclk_in = ~mclk_in;

  // ========================================================================
  // Shared drivers
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task rf(input logic on, input logic off, input logic clr);
    @(posedge mclk_in);
    rf_on_req_in <= on; rf_off_req_in <= off; clear_errors_command_in <= clr;
    @(posedge mclk_in);
    rf_on_req_in <= 0; rf_off_req_in <= 0; clear_errors_command_in <= 0;
    #1;
  endtask
  task smp(input logic [15:0] f, input logic [15:0] r, input logic [15:0] t,
           input logic [15:0] w);
    @(posedge mclk_in);
    fwd_meas_in <= f; refl_meas_in <= r; temp_meas_in <= t; fwd_watts_in <= w;
    sample_valid_in <= 1;
    @(posedge mclk_in);
    sample_valid_in <= 0;
    #1;
  endtask
  task q(input soamon_query_t k, input logic [3:0] c, input logic [3:0] ty);
    @(posedge mclk_in);
    h_req <= 1; h_kind <= k; h_chan <= c; h_type <= ty;
    @(posedge mclk_in);
    h_req <= 0;
    @(posedge mclk_in);
    #1;
    `CHK("reply_valid", 1'b1, reply_valid_out)
    `CHK("reply_kind", k, reply_kind_out)
  endtask
  task cfg(input logic [3:0] t, input logic e);
    @(posedge mclk_in);
    cfg_we_in <= 1; cfg_type_in <= t; cfg_enable_in <= e;
    @(posedge mclk_in);
    cfg_we_in <= 0;
  endtask

  // ========================================================================
  // Scenarios
  task t_defaults;
    q(SOAMON_Q_ENABLE_ALL, 4'h1, 4'h0);
    `CHK("flags_all", 8'h85, reply_flags_out)
    q(SOAMON_Q_REFL_THR, 4'h1, 4'h0);
    `CHK("refl_high", 16'h1275, reply_thr_a_out)
    `CHK("refl_shdn", 16'h1284, reply_thr_b_out)
    q(SOAMON_Q_TEMP_THR, 4'h2, 4'h0);
    `CHK("temp_high", 16'h0226, reply_thr_a_out)
    `CHK("temp_shdn", 16'h028a, reply_thr_b_out)
    `CHK("thr_chan", 4'h2, reply_chan_out)
  endtask
  task t_refl;
    @(posedge mclk_in);
    thr_we_in <= 1; refl_high_in <= 16'h1000; refl_shdn_in <= 16'h1100;
    temp_high_in <= 16'h0226; temp_shdn_in <= 16'h028a;
    @(posedge mclk_in);
    thr_we_in <= 0;
    q(SOAMON_Q_REFL_THR, 4'h1, 4'h0);
    `CHK("refl_high_new", 16'h1000, reply_thr_a_out)
    rf(1, 0, 0);
    `CHK("rf_on", 1'b1, rf_enable_out)
    smp(16'h0700, 16'h1000, 16'h0100, 16'h0000);
    `CHK("refl_equal", 1'b0, status_out[ST_REFL_HIGH])
    `CHK("track_up", 1'b1, drive_up_out)
    smp(16'h0700, 16'h1050, 16'h0100, 16'h0000);
    `CHK("refl_high", 1'b1, status_out[ST_REFL_HIGH])
    `CHK("throttle_dn", 1'b1, drive_down_out)
    `CHK("throttle_up", 1'b0, drive_up_out)
    smp(16'h0800, 16'h0100, 16'h0100, 16'h0000);
    `CHK("refl_sticky", 1'b1, status_out[ST_REFL_HIGH])
    smp(16'h0800, 16'h1101, 16'h0100, 16'h0000);
    `CHK("refl_shdn", 1'b1, status_out[ST_REFL_SHDN])
    `CHK("refl_rf_off", 1'b0, rf_enable_out)
    rf(1, 0, 0);
    `CHK("refused", 1'b1, rf_on_refused_out)
    `CHK("still_off", 1'b0, rf_enable_out)
    rf(0, 0, 1);
    `CHK("cleared", 5'h00, status_out)
    rf(1, 0, 0);
    `CHK("rf_back_on", 1'b1, rf_enable_out)
  endtask
  task t_temp;
    @(posedge mclk_in);
    max_power_cap_in <= 16'h03e8;
    smp(16'h0800, 16'h0100, 16'h0258, 16'h0000);
    `CHK("temp_high", 1'b1, status_out[ST_TEMP_HIGH])
    repeat (34) @(posedge mclk_in);
    #1;
    `CHK("cap_derated", 16'h01f4, max_power_cap_out)
    smp(16'h0800, 16'h0100, 16'h0258, 16'h0258);
    `CHK("cap_clamp", 1'b1, drive_down_out)
    // The divider started by the clamp sample must finish before a new sample
    repeat (34) @(posedge mclk_in);
    smp(16'h0800, 16'h0100, 16'h01f4, 16'h0000);
    @(posedge mclk_in);
    #1;
    `CHK("cap_full", 16'h03e8, max_power_cap_out)
    `CHK("temp_sticky", 1'b1, status_out[ST_TEMP_HIGH])
    smp(16'h0800, 16'h0100, 16'h028b, 16'h0000);
    `CHK("temp_shdn", 1'b1, status_out[ST_TEMP_SHDN])
    `CHK("temp_rf_off", 1'b0, rf_enable_out)
  endtask
  task t_enables;
    rf(1, 0, 1);
    cfg(SOA_TYPE_REFL, 1'b0);
    cfg(SOA_TYPE_INT_WDG, 1'b0);
    smp(16'h0800, 16'h1200, 16'h0100, 16'h0000);
    `CHK("dis_status", 5'h00, status_out)
    `CHK("dis_rf", 1'b1, rf_enable_out)
    rf(0, 1, 0);
    `CHK("rf_off_req", 1'b0, rf_enable_out)
    for (int i = 0; i < SOA_TYPES; i++) begin
      q(SOAMON_Q_ENABLE_ONE, 4'h3, 4'(i));
      `CHK("one_flag", (i == 0 || i == 1 || i == 7), reply_flags_out[0])
      `CHK("one_type", 4'(i), reply_type_out)
      `CHK("one_chan", 4'h3, reply_chan_out)
    end
    q(SOAMON_Q_ENABLE_ONE, 4'h3, 4'ha);
    `CHK("one_flag_bad", 1'b0, reply_flags_out[0])
    q(SOAMON_Q_ENABLE_ALL, 4'h3, 4'h0);
    `CHK("all_flags", 8'h81, reply_flags_out)
    q(SOAMON_Q_NONE, 4'h3, 4'h0);
    `CHK("none_flags", 8'h00, reply_flags_out)
    `CHK("none_thr", 16'h0000, reply_thr_a_out)
  endtask

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (10) @(posedge mclk_in);
    reset_n_in <= 1;
    autogain_in <= 1;
    fwd_setpoint_in <= 16'h0800;
    repeat (5) @(posedge mclk_in);
    t_defaults;
    t_refl;
    t_temp;
    t_enables;
    tally_and_finish;
  end
endmodule // soamon_tb_top
